/* irtc_timer_bank.sv */
// Functional notes
// - bank decode: control 00h-01h, 02h unimplemented (reads zero), reserved 03h, holds 04h-07h, captures 08h-0Bh.
// - byte count for high interval goes to capture-high, low to capture-low; read-only.
// - word timer value captured msb/lsb into two read-only registers.
// - word timer hold value readable and writable as msb and lsb bytes.
// - byte timer high-level and low-level hold registers, readable and writable.
// - control bit 7 starts or stops the byte timer, reads run state, resets 0.
// - bit 6 clear reloads and continues at terminal count; set stops there.
// - bit 5 set at terminal count; writing 1 clears, writing 0 keeps.
// - bits 4:3 pick count clock: full, half, quarter or eighth rate.
// - bit 2 enables the interrupt on capture of an edge in demodulation.
// - bit 1 enables the interrupt on terminal count.
// - bit 0 routes byte timer output to the timer pin; resets 0.
// - first count clock after enable may come early or be short.
// - shared mode bit: 0 transmit, 1 demodulation; resets to transmit.
// - shared edge field: falling, rising, both, reserved.
`default_nettype none
module irtc_timer_bank (
   input  wire logic       clk_i,       // system clock
   input  wire logic       rst_i,       // async reset, active high
   input  wire logic [3:0] reg_addr_i,  // bank register index
   input  wire logic       reg_wr_i,    // write strobe
   input  wire logic       reg_rd_i,    // read strobe
   input  wire logic [7:0] reg_wdata_i, // write data
   output logic      [7:0] reg_rdata_o, // read data, one cycle later
   input  wire logic       demod_in_i,  // demodulator input signal
   input  wire logic       port_data_i, // ordinary port output value
   output logic            timer_pin_o, // timer output pin
   output logic            timeout_irq_o, // terminal count interrupt
   output logic            capture_irq_o  // capture interrupt
);
   logic [7:0]  byte_ctrl_r;
   logic [7:0]  shared_ctrl_r;
   logic [7:0]  low_level_reload_r;
   logic [7:0]  high_level_reload_r;
   logic [7:0]  word_reload_lower_r;
   logic [7:0]  word_reload_upper_r;
   logic [7:0]  word_capture_lower_r;
   logic [7:0]  word_capture_upper_r;
   logic [7:0]  low_interval_count_r;
   logic [7:0]  high_interval_count_r;
   logic [7:0]  byte_cnt_r;
   logic [15:0] word_cnt_r;
   logic        byte_out_r;
   logic        run_d_r;

   logic        wr_ctrl;
   logic        wr_shared;
   logic        byte_timer_run;
   logic        demod;
   logic        cen;
   logic        tc;
   logic        start;
   logic        rise;
   logic        fall;
   logic        hit;
   logic        prev_lvl;
   logic        cap_evt;
   logic        stop_single;

   assign wr_ctrl        = reg_wr_i && reg_addr_i == irtc_pkg::ADDR_BYTE_CTRL;
   assign wr_shared      = reg_wr_i && reg_addr_i == irtc_pkg::ADDR_SHARED_CTRL;
   assign byte_timer_run = byte_ctrl_r[irtc_pkg::BIT_RUN];
   assign demod          = shared_ctrl_r[irtc_pkg::BIT_MODE];
   assign start          = byte_timer_run && !run_d_r;
   assign cap_evt        = demod && byte_timer_run && hit;
   // demodulation counts up and times out at all ones; transmit counts down to zero
   assign tc = byte_timer_run && cen && !start && !cap_evt &&
               (byte_cnt_r == (demod ? irtc_pkg::CNT_TERM_UP : irtc_pkg::CNT_TERM_DOWN));
   assign stop_single    = tc && byte_ctrl_r[irtc_pkg::BIT_SINGLE];

   irtc_clk_div u_count_clock_divider (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .sel_i (irtc_pkg::irtc_clk_sel_t'(byte_ctrl_r[irtc_pkg::BIT_CLK_HI:irtc_pkg::BIT_CLK_LO])),
      .cen_o (cen)
   );

   irtc_edge_det u_edge (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .in_i   (demod_in_i),
      .sel_i  (irtc_pkg::irtc_edge_sel_t'(shared_ctrl_r[irtc_pkg::BIT_EDGE_HI:irtc_pkg::BIT_EDGE_LO])),
      .rise_o (rise),
      .fall_o (fall),
      .hit_o  (hit),
      .prev_o (prev_lvl)
   );

   // byte timer control; hardware set of the time-out flag wins over a clear
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         byte_ctrl_r <= irtc_pkg::RST_BYTE_CTRL;
      end else begin
         if (wr_ctrl) begin
            byte_ctrl_r[7:6] <= reg_wdata_i[7:6];
            byte_ctrl_r[4:0] <= reg_wdata_i[4:0];
         end else if (stop_single) begin
            byte_ctrl_r[irtc_pkg::BIT_RUN] <= 1'b0;
         end
         if (tc) begin
            byte_ctrl_r[irtc_pkg::BIT_TIMEOUT] <= 1'b1;
         end else if (wr_ctrl && reg_wdata_i[irtc_pkg::BIT_TIMEOUT]) begin
            byte_ctrl_r[irtc_pkg::BIT_TIMEOUT] <= 1'b0;
         end
      end
   end

   // shared control: mode, edge select, and edge flags in demodulation
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         shared_ctrl_r <= irtc_pkg::RST_SHARED_CTRL;
      end else begin
         if (wr_shared) begin
            shared_ctrl_r[7:2] <= reg_wdata_i[7:2];
         end
         if (demod && rise) begin
            shared_ctrl_r[irtc_pkg::BIT_RISE_FLG] <= 1'b1;
         end else if (wr_shared) begin
            shared_ctrl_r[irtc_pkg::BIT_RISE_FLG] <= demod ? shared_ctrl_r[irtc_pkg::BIT_RISE_FLG] &
               ~reg_wdata_i[irtc_pkg::BIT_RISE_FLG] : reg_wdata_i[irtc_pkg::BIT_RISE_FLG];
         end
         if (demod && fall) begin
            shared_ctrl_r[irtc_pkg::BIT_FALL_FLG] <= 1'b1;
         end else if (wr_shared) begin
            shared_ctrl_r[irtc_pkg::BIT_FALL_FLG] <= demod ? shared_ctrl_r[irtc_pkg::BIT_FALL_FLG] &
               ~reg_wdata_i[irtc_pkg::BIT_FALL_FLG] : reg_wdata_i[irtc_pkg::BIT_FALL_FLG];
         end
      end
   end

   // hold registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         low_level_reload_r  <= irtc_pkg::RST_DATA;
         high_level_reload_r <= irtc_pkg::RST_DATA;
         word_reload_lower_r <= irtc_pkg::RST_DATA;
         word_reload_upper_r <= irtc_pkg::RST_DATA;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            irtc_pkg::ADDR_LOW_HOLD:  low_level_reload_r  <= reg_wdata_i;
            irtc_pkg::ADDR_HIGH_HOLD: high_level_reload_r <= reg_wdata_i;
            irtc_pkg::ADDR_WHOLD_LSB: word_reload_lower_r <= reg_wdata_i;
            irtc_pkg::ADDR_WHOLD_MSB: word_reload_upper_r <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   // byte counter and its output level
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         byte_cnt_r <= irtc_pkg::RST_DATA;
         byte_out_r <= 1'b0;
         run_d_r    <= 1'b0;
      end else begin
         run_d_r <= byte_timer_run;
         if (start) begin
            byte_cnt_r <= demod ? irtc_pkg::RST_DATA : low_level_reload_r;
            byte_out_r <= 1'b0;
         end else if (cap_evt) begin
            byte_cnt_r <= irtc_pkg::RST_DATA;
         end else if (tc) begin
            if (!demod) begin
               // reload the hold that matches the new level
               byte_cnt_r <= byte_out_r ? low_level_reload_r : high_level_reload_r;
               byte_out_r <= ~byte_out_r;
            end else begin
               byte_cnt_r <= irtc_pkg::RST_DATA;
            end
         end else if (byte_timer_run && cen) begin
            byte_cnt_r <= demod ? byte_cnt_r + 8'h01 : byte_cnt_r - 8'h01;
         end
      end
   end

   // captures; writes to these addresses have no path here
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         word_cnt_r            <= 16'h0000;
         word_capture_lower_r  <= irtc_pkg::RST_DATA;
         word_capture_upper_r  <= irtc_pkg::RST_DATA;
         low_interval_count_r  <= irtc_pkg::RST_DATA;
         high_interval_count_r <= irtc_pkg::RST_DATA;
      end else begin
         if (cap_evt) begin
            word_cnt_r           <= 16'h0000;
            word_capture_lower_r <= word_cnt_r[7:0];
            word_capture_upper_r <= word_cnt_r[15:8];
            if (prev_lvl) begin
               high_interval_count_r <= byte_cnt_r;
            end else begin
               low_interval_count_r <= byte_cnt_r;
            end
         end else if (demod && byte_timer_run) begin
            word_cnt_r <= word_cnt_r + 16'h0001;
         end
      end
   end

   // outputs, all registered
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         timer_pin_o   <= 1'b0;
         timeout_irq_o <= 1'b0;
         capture_irq_o <= 1'b0;
      end else begin
         timer_pin_o   <= byte_ctrl_r[irtc_pkg::BIT_PIN_SEL] ? byte_out_r : port_data_i;
         timeout_irq_o <= tc && byte_ctrl_r[irtc_pkg::BIT_TO_IEN];
         capture_irq_o <= cap_evt && byte_ctrl_r[irtc_pkg::BIT_CAP_IEN];
      end
   end

   // read port; reserved and unimplemented slots read zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= irtc_pkg::RST_DATA;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            irtc_pkg::ADDR_BYTE_CTRL:   reg_rdata_o <= byte_ctrl_r;
            irtc_pkg::ADDR_SHARED_CTRL: reg_rdata_o <= shared_ctrl_r;
            irtc_pkg::ADDR_LOW_HOLD:    reg_rdata_o <= low_level_reload_r;
            irtc_pkg::ADDR_HIGH_HOLD:   reg_rdata_o <= high_level_reload_r;
            irtc_pkg::ADDR_WHOLD_LSB:   reg_rdata_o <= word_reload_lower_r;
            irtc_pkg::ADDR_WHOLD_MSB:   reg_rdata_o <= word_reload_upper_r;
            irtc_pkg::ADDR_WCAP_LSB:    reg_rdata_o <= word_capture_lower_r;
            irtc_pkg::ADDR_WCAP_MSB:    reg_rdata_o <= word_capture_upper_r;
            irtc_pkg::ADDR_CAP_LOW:     reg_rdata_o <= low_interval_count_r;
            irtc_pkg::ADDR_CAP_HIGH:    reg_rdata_o <= high_interval_count_r;
            default:                    reg_rdata_o <= irtc_pkg::RST_DATA;
         endcase
      end
   end

   property p_tc_sets_flag;
      @(posedge clk_i) disable iff (rst_i)
      tc |=> byte_ctrl_r[irtc_pkg::BIT_TIMEOUT];
   endproperty
   a_tc_sets_flag: assert property (p_tc_sets_flag) else $error("timeout flag not set");

   property p_flag_w1c;
      @(posedge clk_i) disable iff (rst_i)
      (wr_ctrl && reg_wdata_i[irtc_pkg::BIT_TIMEOUT] && !tc) |=> !byte_ctrl_r[irtc_pkg::BIT_TIMEOUT];
   endproperty
   a_flag_w1c: assert property (p_flag_w1c) else $error("write 1 did not clear flag");

   property p_flag_w0_keeps;
      @(posedge clk_i) disable iff (rst_i)
      (wr_ctrl && !reg_wdata_i[irtc_pkg::BIT_TIMEOUT]) |=> $stable(byte_ctrl_r[irtc_pkg::BIT_TIMEOUT])
         || byte_ctrl_r[irtc_pkg::BIT_TIMEOUT];
   endproperty
   a_flag_w0_keeps: assert property (p_flag_w0_keeps) else $error("write 0 changed flag");

   property p_cap_high;
      @(posedge clk_i) disable iff (rst_i)
      (cap_evt && prev_lvl) |=> high_interval_count_r == $past(byte_cnt_r) && byte_cnt_r == 8'h00;
   endproperty
   a_cap_high: assert property (p_cap_high) else $error("high interval not captured");

   property p_cap_low;
      @(posedge clk_i) disable iff (rst_i)
      (cap_evt && !prev_lvl) |=> low_interval_count_r == $past(byte_cnt_r) && $stable(high_interval_count_r);
   endproperty
   a_cap_low: assert property (p_cap_low) else $error("low interval not captured");

   property p_cap_readonly;
      @(posedge clk_i) disable iff (rst_i)
      (!cap_evt) |=> $stable(low_interval_count_r) && $stable(word_capture_upper_r);
   endproperty
   a_cap_readonly: assert property (p_cap_readonly) else $error("capture changed without edge");

   property p_to_irq;
      @(posedge clk_i) disable iff (rst_i)
      tc |=> timeout_irq_o == $past(byte_ctrl_r[irtc_pkg::BIT_TO_IEN]);
   endproperty
   a_to_irq: assert property (p_to_irq) else $error("timeout interrupt wrong");

   property p_cap_irq;
      @(posedge clk_i) disable iff (rst_i)
      capture_irq_o |-> $past(cap_evt) && $past(byte_ctrl_r[irtc_pkg::BIT_CAP_IEN]);
   endproperty
   a_cap_irq: assert property (p_cap_irq) else $error("capture interrupt without cause");

   property p_single_stops;
      @(posedge clk_i) disable iff (rst_i)
      (stop_single && !wr_ctrl) |=> !byte_ctrl_r[irtc_pkg::BIT_RUN] ##1 $stable(byte_cnt_r);
   endproperty
   a_single_stops: assert property (p_single_stops) else $error("single pass kept running");

   property p_pin_route;
      @(posedge clk_i) disable iff (rst_i)
      byte_ctrl_r[irtc_pkg::BIT_PIN_SEL] |=> timer_pin_o == $past(byte_out_r);
   endproperty
   a_pin_route: assert property (p_pin_route) else $error("pin not routed to timer");

   c_timeout: cover property (@(posedge clk_i) disable iff (rst_i) tc ##1 timeout_irq_o);
   c_cap_both: cover property (@(posedge clk_i) disable iff (rst_i) (cap_evt && prev_lvl) ##[1:50] (cap_evt && !prev_lvl));
   c_set_vs_clear: cover property (@(posedge clk_i) disable iff (rst_i) tc && wr_ctrl && reg_wdata_i[5]);
endmodule : irtc_timer_bank
`default_nettype wire

/* irtc_pkg.sv */
`default_nettype none
package irtc_pkg;
   localparam logic [3:0] ADDR_BYTE_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_SHARED_CTRL = 4'h1;
   localparam logic [3:0] ADDR_WORD_CTRL   = 4'h2;
   localparam logic [3:0] ADDR_RESERVED    = 4'h3;
   localparam logic [3:0] ADDR_LOW_HOLD    = 4'h4;
   localparam logic [3:0] ADDR_HIGH_HOLD   = 4'h5;
   localparam logic [3:0] ADDR_WHOLD_LSB   = 4'h6;
   localparam logic [3:0] ADDR_WHOLD_MSB   = 4'h7;
   localparam logic [3:0] ADDR_WCAP_LSB    = 4'h8;
   localparam logic [3:0] ADDR_WCAP_MSB    = 4'h9;
   localparam logic [3:0] ADDR_CAP_LOW     = 4'hA;
   localparam logic [3:0] ADDR_CAP_HIGH    = 4'hB;

   // byte timer control fields
   localparam int BIT_RUN      = 7;
   localparam int BIT_SINGLE   = 6;
   localparam int BIT_TIMEOUT  = 5;
   localparam int BIT_CLK_HI   = 4;
   localparam int BIT_CLK_LO   = 3;
   localparam int BIT_CAP_IEN  = 2;
   localparam int BIT_TO_IEN   = 1;
   localparam int BIT_PIN_SEL  = 0;

   // shared control fields
   localparam int BIT_MODE     = 7;
   localparam int BIT_EDGE_HI  = 5;
   localparam int BIT_EDGE_LO  = 4;
   localparam int BIT_RISE_FLG = 1;
   localparam int BIT_FALL_FLG = 0;

   localparam logic [7:0] RST_BYTE_CTRL   = 8'h00;
   localparam logic [7:0] RST_SHARED_CTRL = 8'h00;
   localparam logic [7:0] RST_DATA        = 8'h00;
   localparam logic [7:0] CNT_TERM_UP     = 8'hFF;
   localparam logic [7:0] CNT_TERM_DOWN   = 8'h00;

   typedef enum logic [1:0] {
      IRTC_CLK_DIV1 = 2'b00,
      IRTC_CLK_DIV2 = 2'b01,
      IRTC_CLK_DIV4 = 2'b10,
      IRTC_CLK_DIV8 = 2'b11
   } irtc_clk_sel_t;

   typedef enum logic [1:0] {
      IRTC_EDGE_FALL = 2'b00,
      IRTC_EDGE_RISE = 2'b01,
      IRTC_EDGE_BOTH = 2'b10,
      IRTC_EDGE_RSVD = 2'b11
   } irtc_edge_sel_t;
endpackage : irtc_pkg
`default_nettype wire

/* irtc_clk_div.sv */
`default_nettype none
module irtc_clk_div (
   input  wire logic                   clk_i,  // system clock
   input  wire logic                   rst_i,  // async reset
   input  wire irtc_pkg::irtc_clk_sel_t sel_i, // divide select
   output logic                        cen_o   // count enable pulse
);
   logic [2:0] div_r;

   // free running, so the first pulse after enable lands anywhere
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_r <= 3'h0;
      end else begin
         div_r <= div_r + 3'h1;
      end
   end

   always_comb begin
      unique case (sel_i)
         irtc_pkg::IRTC_CLK_DIV1: cen_o = 1'b1;
         irtc_pkg::IRTC_CLK_DIV2: cen_o = div_r[0];
         irtc_pkg::IRTC_CLK_DIV4: cen_o = &div_r[1:0];
         irtc_pkg::IRTC_CLK_DIV8: cen_o = &div_r;
      endcase
   end

   property p_div8;
      @(posedge clk_i) disable iff (rst_i)
      (cen_o && sel_i == irtc_pkg::IRTC_CLK_DIV8) |=>
         (!cen_o || sel_i != irtc_pkg::IRTC_CLK_DIV8)[*7];
   endproperty
   a_div8: assert property (p_div8) else $error("divide by 8 pulse too early");
endmodule : irtc_clk_div
`default_nettype wire

/* irtc_edge_det.sv */
`default_nettype none
module irtc_edge_det (
   input  wire logic                    clk_i,  // system clock
   input  wire logic                    rst_i,  // async reset
   input  wire logic                    in_i,   // demodulator input
   input  wire irtc_pkg::irtc_edge_sel_t sel_i, // edge select
   output logic                         rise_o, // rising edge seen
   output logic                         fall_o, // falling edge seen
   output logic                         hit_o,  // selected edge
   output logic                         prev_o  // level of ended interval
);
   logic prev_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= in_i;
      end
   end

   assign rise_o = in_i & ~prev_r;
   assign fall_o = ~in_i & prev_r;
   assign prev_o = prev_r;

   always_comb begin
      unique case (sel_i)
         irtc_pkg::IRTC_EDGE_FALL: hit_o = fall_o;
         irtc_pkg::IRTC_EDGE_RISE: hit_o = rise_o;
         irtc_pkg::IRTC_EDGE_BOTH: hit_o = rise_o | fall_o;
         irtc_pkg::IRTC_EDGE_RSVD: hit_o = 1'b0;
      endcase
   end

   property p_hit_is_change;
      @(posedge clk_i) disable iff (rst_i)
      hit_o |-> (in_i != prev_r) && (sel_i != irtc_pkg::IRTC_EDGE_RSVD);
   endproperty
   a_hit_is_change: assert property (p_hit_is_change) else $error("edge without change");
endmodule : irtc_edge_det
`default_nettype wire

/* tb_top.sv */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_i      = 1'b0;
   logic       rst_i      = 1'b1;
   logic [3:0] addr       = 4'h0;
   logic       wr         = 1'b0;
   logic       rd         = 1'b0;
   logic [7:0] wdata      = 8'h00;
   logic       din        = 1'b0;
   logic       pdat       = 1'b0;
   logic [7:0] rdata;
   logic       pin;
   logic       to_irq;
   logic       cap_irq;
   int         n_fail     = 0;
   int         n_compared = 0;
   int         cyc        = 0;
   int         n_cap      = 0;
   int         c0;
   int         t0;
   int         to_cyc[$];
   logic       to_pin[$];
   logic [7:0] v;
   logic [7:0] v2;

   irtc_timer_bank uut (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .reg_addr_i    (addr),
      .reg_wr_i      (wr),
      .reg_rd_i      (rd),
      .reg_wdata_i   (wdata),
      .reg_rdata_o   (rdata),
      .demod_in_i    (din),
      .port_data_i   (pdat),
      .timer_pin_o   (pin),
      .timeout_irq_o (to_irq),
      .capture_irq_o (cap_irq)
   );

   always #10 clk_i = ~clk_i;

   // pin is logged with each time-out pulse; the pin lags a cycle, so it shows the phase just ended
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cap_irq === 1'b1)
         n_cap <= n_cap + 1;
      if (to_irq === 1'b1) begin
         to_cyc.push_back(cyc);
         to_pin.push_back(pin);
      end
   end

   task automatic test_done;
      if (n_fail == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
         n_fail++;
      end
   endtask : check

   // divider phase makes captured counts drift by a count or two
   function automatic logic [15:0] near(input logic [15:0] s, input int e, input int t);
      return {15'h0000, (s + t >= e) && (s <= e + t)};
   endfunction : near

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_i);
      wr    <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_i);
      rd   <= 1'b0;
      @(negedge clk_i);
      d = rdata;
   endtask : rd_reg

   task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd_reg(a, d);
      check(what, {8'h00, d}, {8'h00, e});
   endtask : rd_chk

   task automatic wait_irq(input int n);
      int k;
      k = 0;
      while (to_cyc.size() < n) begin
         @(posedge clk_i);
         k++;
         if (k > 600) begin
            n_fail++;
            test_done();
         end
      end
   endtask : wait_irq

   // stop, clear the flag and let a late pulse pass before logging
   task automatic restart(input logic [7:0] ctrl);
      wr_reg(4'h0, 8'h20);
      repeat (4) @(posedge clk_i);
      to_cyc.delete();
      to_pin.delete();
      wr_reg(4'h0, ctrl);
   endtask : restart

   task automatic set_in(input logic b, input int hold);
      @(posedge clk_i);
      din <= b;
      repeat (hold) @(posedge clk_i);
   endtask : set_in

   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 16; a++)
         rd_chk("reset value", 4'(a), 8'h00);
      for (int a = 4; a < 8; a++)
         wr_reg(4'(a), 8'hA5 ^ 8'(a));
      for (int a = 4; a < 8; a++)
         rd_chk("hold register", 4'(a), 8'hA5 ^ 8'(a));
      for (int a = 2; a < 12; a++)
         if (a < 4 || a > 7)
            wr_reg(4'(a), 8'hFF);
      for (int a = 2; a < 12; a++)
         if (a < 4 || a > 7)
            rd_chk("read only", 4'(a), 8'h00);
      @(posedge clk_i);
      pdat <= 1'b1;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      check("port pin", {15'h0000, pin}, 16'h0001);
      wr_reg(4'h4, 8'h02);
      wr_reg(4'h5, 8'h05);
      for (int s = 0; s < 4; s++) begin
         restart(8'h83 | 8'(s << 3));
         wait_irq(3);
         check("timeout gap", 16'(to_cyc[2] - to_cyc[0]), 16'(9 << s));
         check("timer pin", {14'h0000, to_pin[0], to_pin[1]}, 16'h0001);
      end
      restart(8'hC2);
      wait_irq(1);
      repeat (40) @(posedge clk_i);
      check("single pass", 16'(to_cyc.size()), 16'h0001);
      rd_chk("stopped ctrl", 4'h0, 8'h62);
      wr_reg(4'h0, 8'h42);
      rd_chk("flag kept", 4'h0, 8'h62);
      wr_reg(4'h0, 8'h62);
      rd_chk("flag cleared", 4'h0, 8'h42);
      restart(8'h80);
      repeat (30) @(posedge clk_i);
      wr_reg(4'h0, 8'h00);
      check("masked timeout", 16'(to_cyc.size()), 16'h0000);
      rd_chk("flag unmasked", 4'h0, 8'h20);
      for (int e = 0; e < 4; e++) begin
         wr_reg(4'h1, 8'h80 | 8'(e << 4));
         wr_reg(4'h0, 8'h84);
         c0 = n_cap;
         set_in(1'b1, 40);
         set_in(1'b0, 20);
         check("edge captures", 16'(n_cap - c0), (e == 2) ? 16'h0002 : (e == 3) ? 16'h0000 : 16'h0001);
         rd_chk("edge flags", 4'h1, 8'h83 | 8'(e << 4));
         wr_reg(4'h1, 8'h83 | 8'(e << 4));
         rd_chk("edge flags cleared", 4'h1, 8'h80 | 8'(e << 4));
         wr_reg(4'h0, 8'h00);
      end
      wr_reg(4'h1, 8'hA0);
      c0 = n_cap;
      wr_reg(4'h0, 8'h9C);
      set_in(1'b1, 320);
      set_in(1'b0, 0);
      t0 = cyc;
      rd_reg(4'hB, v);
      check("high interval", near({8'h00, v}, 40, 2), 16'h0001);
      rd_reg(4'h8, v);
      rd_reg(4'h9, v2);
      check("word high", near({v2, v}, 321, 3), 16'h0001);
      while (cyc < t0 + 600)
         @(posedge clk_i);
      set_in(1'b1, 8);
      rd_reg(4'hA, v);
      check("low interval", near({8'h00, v}, 75, 2), 16'h0001);
      rd_reg(4'h8, v);
      rd_reg(4'h9, v2);
      check("word low", near({v2, v}, 601, 3), 16'h0001);
      check("capture pulses", 16'(n_cap - c0), 16'h0003);
      // input held steady, so the up count runs to all ones and wraps
      restart(8'h82);
      wait_irq(2);
      check("demod wrap", 16'(to_cyc[1] - to_cyc[0]), 16'h0100);
      wr_reg(4'h0, 8'h00);
      test_done();
   end
endmodule : tb_top
`default_nettype wire
